// *** verilog/ww_params.svh ***
// offsets, field positions, reset values and timing figures of the control bank
`ifndef WW_PARAMS_SVH
`define WW_PARAMS_SVH

// register indices; byte address is four times the index
`define WW_IDX_PROT 14'h00b2
`define WW_IDX_WDRST 14'h00f8
`define WW_IDX_WDOVF 14'h2002
`define WW_IDX_REF 14'h2004
`define WW_IDX_VER 14'h2006
`define WW_IDX_KEY 14'h201f
`define WW_IDX_WAKE 14'h20a9
`define WW_IDX_NEAR 14'h20b1
`define WW_IDX_TSEL 14'h20fd
`define WW_IDX_TRIM 14'h20ff
`define WW_IDX_ISTAT 14'h2100
`define WW_IDX_IMASK 14'h2101

// field positions
`define WW_B_BOOTPROT 5
`define WW_B_ENGPROT 4
`define WW_B_WDOVF 2
`define WW_B_REFPAD 7
`define WW_B_REFDIS 3
`define WW_B_ARM 7
`define WW_B_RES 3
`define WW_B_NEAR 0

// values
`define WW_RESTART_KEY 8'hff
`define WW_PRD_RESET 3'h1
`define WW_TSEL_REFMAG 4'h1
`define WW_KB_SHIFT 10
`define WW_RESP_OKAY 2'h0
`define WW_RESP_SLVERR 2'h2

// autowake step lengths in milliseconds, with the rtc tick rate
`define WW_RTC_HZ 32768
`define WW_STEP_SHORT_MS 2500
`define WW_STEP_LONG_MS 60000

`endif

// *** verilog/ww_pkg.sv ***
// state types of the control bank
package ww_pkg;
	typedef struct packed {
		logic aw_held;
		logic [13:0] aw_idx;
		logic w_held;
		logic [7:0] w_data;
		logic w_be;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic eng_prot;
		logic boot_prot;
		logic watchdog_overflow_status;
		logic ref_dis;
		logic ref_pad;
		logic [2:0] prd;
		logic res;
		logic near;
		logic [3:0] tsel;
		logic [3:0] istat;
		logic [3:0] imask;
		logic wd_restart;
		logic arm;
		logic [7:0] key;
		logic key_stb;
		logic wake_s1;
		logic wake_s2;
		logic wake_s3;
		logic rpin_s1;
		logic rpin_s2;
	} ww_bank_t;

	typedef struct packed {
		logic armed;
		logic res_q;
		logic [2:0] steps;
		logic [20:0] unit_cnt;
		logic expire;
	} ww_wake_t;

	typedef struct packed {
		logic grant;
		logic blocked;
	} ww_guard_t;
endpackage

// *** verilog/ww_wake_timer.sv ***
// autowake timer counting rtc ticks in steps of the selected resolution
`timescale 1ns/10ps
module ww_wake_timer #(
	parameter int SHORT_TICKS = 81920,
	parameter int LONG_TICKS = 1966080
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic rtc_tick,
	input wire logic arm,
	input wire logic [2:0] period,
	input wire logic res,
	input wire logic hold_reset,
	output logic armed,
	output logic expire
);
	ww_pkg::ww_wake_t r_ff, nxt_r;
	logic [20:0] limit;

	always_comb begin
		limit = r_ff.res_q ? 21'(LONG_TICKS - 1) : 21'(SHORT_TICKS - 1);
		nxt_r = r_ff;
		nxt_r.expire = 1'b0;
		if (hold_reset) begin
			nxt_r.armed = 1'b0;
			nxt_r.unit_cnt = '0;
			nxt_r.steps = '0;
		end else if (arm) begin
			nxt_r.armed = 1'b1;
			nxt_r.steps = period;
			nxt_r.res_q = res;
			nxt_r.unit_cnt = '0;
		end else if (r_ff.armed && rtc_tick) begin
			if (r_ff.unit_cnt == limit) begin
				nxt_r.unit_cnt = '0;
				if (r_ff.steps <= 3'h1) begin
					nxt_r.armed = 1'b0;
					nxt_r.expire = 1'b1;
				end else begin
					nxt_r.steps = r_ff.steps - 3'h1;
				end
			end else begin
				nxt_r.unit_cnt = r_ff.unit_cnt + 21'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign armed = r_ff.armed;
	assign expire = r_ff.expire;

	property p_wake_hold;
		@(posedge aclk) disable iff (!aresetn) hold_reset |=> !armed && !expire;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("timer armed in full power");

	property p_wake_arm;
		@(posedge aclk) disable iff (!aresetn)
			(arm && !hold_reset) |=> armed && r_ff.steps == $past(period) && r_ff.unit_cnt == 21'h0;
	endproperty
	a_wake_arm: assert property (p_wake_arm) else $error("arm did not preset timer");
endmodule

// *** verilog/ww_erase_guard.sv ***
// flash page-erase guard for boot and engine code areas
`timescale 1ns/10ps
`include "ww_params.svh"
module ww_erase_guard #(
	parameter int AW = 18
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic erase_req,
	input wire logic [AW-1:0] erase_addr,
	input wire logic [AW-11:0] boot_size,
	input wire logic [AW-11:0] engine_code_location,
	input wire logic boot_prot,
	input wire logic eng_prot,
	output logic erase_grant,
	output logic erase_blocked
);
	ww_pkg::ww_guard_t r_ff, nxt_r;
	logic in_boot;
	logic in_eng;

	always_comb begin
		in_boot = boot_prot && (erase_addr < {boot_size, {`WW_KB_SHIFT{1'b0}}});
		in_eng = eng_prot && (erase_addr >= {engine_code_location, {`WW_KB_SHIFT{1'b0}}});
		nxt_r.grant = erase_req && !(in_boot || in_eng);
		nxt_r.blocked = erase_req && (in_boot || in_eng);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign erase_grant = r_ff.grant;
	assign erase_blocked = r_ff.blocked;

	property p_boot_guard;
		@(posedge aclk) disable iff (!aresetn)
			(erase_req && boot_prot && erase_addr < {boot_size, {`WW_KB_SHIFT{1'b0}}})
			|=> erase_blocked && !erase_grant;
	endproperty
	a_boot_guard: assert property (p_boot_guard) else $error("boot area erase not blocked");

	property p_eng_guard;
		@(posedge aclk) disable iff (!aresetn)
			(erase_req && eng_prot && erase_addr >= {engine_code_location, {`WW_KB_SHIFT{1'b0}}})
			|=> erase_blocked && !erase_grant;
	endproperty
	a_eng_guard: assert property (p_eng_guard) else $error("engine area erase not blocked");
endmodule

// *** verilog/ww_bank.sv ***
// wake, watchdog, trim and protect control bank behind an axi4-lite slave
`timescale 1ns/10ps
`include "ww_params.svh"
// What this block does
// - selector value 1 shows reference magnitude fuse
// - read-only eight-bit silicon version register
// - route reference to pad unless disabled
// - arm write presets and arms autowake
// - autowake held reset in full/battery modes
// - sleep time is period times resolution, period zero giving one step
// - resolution one minute or 2.5 seconds
// - near-overflow flag set before watchdog overflow
// - near flag cleared by zero or wake fall
// - byte write 0xff restarts watchdog
// - overflow sets watchdog overflow status
// - overflow status survives ordinary resets
// - reset pin high and sleep clear status
// - boot protect blocks erase below boot size
// - engine protect blocks erase engine area upward
module ww_bank #(
	parameter logic [7:0] SILICON_REVISION = 8'h5a, // arbitrary value
	parameter int AW = 18,
	parameter int SHORT_TICKS = `WW_STEP_SHORT_MS * `WW_RTC_HZ / 1000,
	parameter int LONG_TICKS = `WW_STEP_LONG_MS * `WW_RTC_HZ / 1000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic nv_por_n,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] reference_magnitude_fuse,
	output logic reference_enable,
	output logic reference_to_pad,
	input wire logic rtc_tick,
	input wire logic full_power_mode,
	input wire logic battery_low_power_mode,
	input wire logic sleep_mode,
	input wire logic wake_in,
	input wire logic reset_pin_in,
	output logic autowake_armed,
	output logic autowake_expire,
	input wire logic watchdog_near_overflow,
	input wire logic watchdog_overflow,
	output logic watchdog_restart,
	output logic [7:0] clock_write_enable_key,
	output logic clock_key_strobe,
	input wire logic erase_req,
	input wire logic [AW-1:0] erase_addr,
	input wire logic [AW-11:0] boot_size,
	input wire logic [AW-11:0] engine_code_location,
	output logic erase_grant,
	output logic erase_blocked,
	output logic irq
);
	// ****************************************
	// state and helpers
	// ****************************************
	ww_pkg::ww_bank_t r_ff, nxt_r;
	logic do_wr;
	logic wr_en;
	logic wake_fall;
	logic [13:0] ar_idx;
	logic [7:0] rd_val;
	logic [7:0] trim_view;

	function automatic logic is_mapped(input logic [13:0] idx);
		case (idx)
			`WW_IDX_PROT, `WW_IDX_WDRST, `WW_IDX_WDOVF, `WW_IDX_REF, `WW_IDX_VER,
			`WW_IDX_KEY, `WW_IDX_WAKE, `WW_IDX_NEAR, `WW_IDX_TSEL, `WW_IDX_TRIM,
			`WW_IDX_ISTAT, `WW_IDX_IMASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// ****************************************
	// submodules
	// ****************************************
	ww_wake_timer #(
		.SHORT_TICKS(SHORT_TICKS),
		.LONG_TICKS(LONG_TICKS)
	) u_wake (
		.aclk(aclk),
		.aresetn(aresetn),
		.rtc_tick(rtc_tick),
		.arm(r_ff.arm),
		.period(r_ff.prd),
		.res(r_ff.res),
		.hold_reset(full_power_mode || battery_low_power_mode),
		.armed(autowake_armed),
		.expire(autowake_expire)
	);

	ww_erase_guard #(
		.AW(AW)
	) u_guard (
		.aclk(aclk),
		.aresetn(aresetn),
		.erase_req(erase_req),
		.erase_addr(erase_addr),
		.boot_size(boot_size),
		.engine_code_location(engine_code_location),
		.boot_prot(r_ff.boot_prot),
		.eng_prot(r_ff.eng_prot),
		.erase_grant(erase_grant),
		.erase_blocked(erase_blocked)
	);

	// ****************************************
	// read decode
	// ****************************************
	assign ar_idx = s_axi_araddr[15:2];
	assign trim_view = (r_ff.tsel == `WW_TSEL_REFMAG) ? reference_magnitude_fuse : 8'h00;

	always_comb begin
		rd_val = 8'h00;
		case (ar_idx)
			`WW_IDX_PROT: begin
				rd_val[`WW_B_BOOTPROT] = r_ff.boot_prot;
				rd_val[`WW_B_ENGPROT] = r_ff.eng_prot;
			end
			`WW_IDX_WDOVF: rd_val[`WW_B_WDOVF] = r_ff.watchdog_overflow_status;
			`WW_IDX_REF: begin
				rd_val[`WW_B_REFPAD] = r_ff.ref_pad;
				rd_val[`WW_B_REFDIS] = r_ff.ref_dis;
			end
			`WW_IDX_VER: rd_val = SILICON_REVISION;
			`WW_IDX_WAKE: rd_val = {4'h0, r_ff.res, r_ff.prd};
			`WW_IDX_NEAR: rd_val[`WW_B_NEAR] = r_ff.near;
			`WW_IDX_TSEL: rd_val = {4'h0, r_ff.tsel};
			`WW_IDX_TRIM: rd_val = trim_view;
			`WW_IDX_ISTAT: rd_val = {4'h0, r_ff.istat};
			`WW_IDX_IMASK: rd_val = {4'h0, r_ff.imask};
			default: rd_val = 8'h00;
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	assign do_wr = r_ff.aw_held && r_ff.w_held;
	assign wr_en = do_wr && r_ff.w_be;
	// the second and third stages feed the edge test, the first stage stays private
	assign wake_fall = r_ff.wake_s3 && !r_ff.wake_s2;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.wd_restart = 1'b0;
		nxt_r.key_stb = 1'b0;
		nxt_r.arm = 1'b0;
		nxt_r.wake_s1 = wake_in;
		nxt_r.wake_s2 = r_ff.wake_s1;
		nxt_r.wake_s3 = r_ff.wake_s2;
		nxt_r.rpin_s1 = reset_pin_in;
		nxt_r.rpin_s2 = r_ff.rpin_s1;

		if (s_axi_awvalid && s_axi_awready) begin
			nxt_r.aw_held = 1'b1;
			nxt_r.aw_idx = s_axi_awaddr[15:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_r.w_held = 1'b1;
			nxt_r.w_data = s_axi_wdata[7:0];
			nxt_r.w_be = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			nxt_r.bvalid = 1'b0;
		end
		if (do_wr) begin
			nxt_r.aw_held = 1'b0;
			nxt_r.w_held = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp = is_mapped(r_ff.aw_idx) ? `WW_RESP_OKAY : `WW_RESP_SLVERR;
		end

		if (wr_en) begin
			case (r_ff.aw_idx)
				`WW_IDX_PROT: begin
					nxt_r.boot_prot = r_ff.w_data[`WW_B_BOOTPROT];
					nxt_r.eng_prot = r_ff.w_data[`WW_B_ENGPROT];
				end
				`WW_IDX_WDRST: nxt_r.wd_restart = (r_ff.w_data == `WW_RESTART_KEY);
				`WW_IDX_WDOVF: nxt_r.watchdog_overflow_status = r_ff.w_data[`WW_B_WDOVF];
				`WW_IDX_REF: begin
					nxt_r.ref_pad = r_ff.w_data[`WW_B_REFPAD];
					nxt_r.ref_dis = r_ff.w_data[`WW_B_REFDIS];
				end
				`WW_IDX_KEY: begin
					nxt_r.key = r_ff.w_data;
					nxt_r.key_stb = 1'b1;
				end
				`WW_IDX_WAKE: begin
					nxt_r.arm = r_ff.w_data[`WW_B_ARM];
					nxt_r.res = r_ff.w_data[`WW_B_RES];
					nxt_r.prd = r_ff.w_data[2:0];
				end
				`WW_IDX_NEAR: nxt_r.near = r_ff.near && r_ff.w_data[`WW_B_NEAR];
				`WW_IDX_TSEL: nxt_r.tsel = r_ff.w_data[3:0];
				`WW_IDX_ISTAT: nxt_r.istat = r_ff.istat & ~r_ff.w_data[3:0];
				`WW_IDX_IMASK: nxt_r.imask = r_ff.w_data[3:0];
				default: nxt_r.key_stb = 1'b0;
			endcase
		end

		if (s_axi_arvalid && s_axi_arready) begin
			nxt_r.rvalid = 1'b1;
			nxt_r.rdata = rd_val;
			nxt_r.rresp = is_mapped(ar_idx) ? `WW_RESP_OKAY : `WW_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			nxt_r.rvalid = 1'b0;
		end

		if (wake_fall) begin
			nxt_r.near = 1'b0;
		end
		// early warning, set wins over clear
		if (watchdog_near_overflow) begin
			nxt_r.near = 1'b1;
		end
		if (watchdog_overflow) begin
			nxt_r.watchdog_overflow_status = 1'b1;
		end
		// pin level and sleep clear the status
		if (r_ff.rpin_s2 || sleep_mode) begin
			nxt_r.watchdog_overflow_status = 1'b0;
		end
		// sticky interrupt sources set after the clear so they win
		nxt_r.istat = nxt_r.istat | {erase_blocked, autowake_expire,
			watchdog_overflow, watchdog_near_overflow};
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!nv_por_n) begin
			r_ff <= '0;
			r_ff.prd <= `WW_PRD_RESET;
		end else if (!aresetn) begin
			r_ff <= '0;
			r_ff.prd <= `WW_PRD_RESET;
			r_ff.watchdog_overflow_status <= r_ff.watchdog_overflow_status;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = !r_ff.aw_held && !r_ff.bvalid;
	assign s_axi_wready = !r_ff.w_held;
	assign s_axi_bvalid = r_ff.bvalid;
	assign s_axi_bresp = r_ff.bresp;
	assign s_axi_arready = !r_ff.rvalid;
	assign s_axi_rvalid = r_ff.rvalid;
	assign s_axi_rdata = {24'h000000, r_ff.rdata};
	assign s_axi_rresp = r_ff.rresp;
	assign reference_enable = !r_ff.ref_dis;
	assign reference_to_pad = r_ff.ref_pad && !r_ff.ref_dis;
	assign watchdog_restart = r_ff.wd_restart;
	assign clock_write_enable_key = r_ff.key;
	assign clock_key_strobe = r_ff.key_stb;
	assign irq = |(r_ff.istat & r_ff.imask);

	// ****************************************
	// checks
	// ****************************************
	property p_ref_pad;
		@(posedge aclk) disable iff (!aresetn) r_ff.ref_dis |-> !reference_to_pad && !reference_enable;
	endproperty
	a_ref_pad: assert property (p_ref_pad) else $error("reference routed while disabled");

	property p_ref_reset;
		@(posedge aclk) disable iff (!nv_por_n) $past(!aresetn) |-> reference_enable;
	endproperty
	a_ref_reset: assert property (p_ref_reset) else $error("reference off after reset");

	property p_restart;
		@(posedge aclk) disable iff (!aresetn)
			(do_wr && r_ff.w_be && r_ff.aw_idx == `WW_IDX_WDRST && r_ff.w_data == `WW_RESTART_KEY)
			|=> watchdog_restart ##1 !watchdog_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart write lost");

	property p_ovf_set;
		@(posedge aclk) disable iff (!aresetn)
			(watchdog_overflow && !r_ff.rpin_s2 && !sleep_mode) |=> r_ff.watchdog_overflow_status;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow status not set");

	property p_ovf_clr;
		@(posedge aclk) disable iff (!aresetn) (r_ff.rpin_s2 || sleep_mode) |=> !r_ff.watchdog_overflow_status;
	endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow status kept under reset pin");

	property p_near_clr;
		@(posedge aclk) disable iff (!aresetn)
			(wake_fall && !watchdog_near_overflow) |=> !r_ff.near;
	endproperty
	a_near_clr: assert property (p_near_clr) else $error("near flag kept after wake fall");

	property p_near_set;
		@(posedge aclk) disable iff (!aresetn) watchdog_near_overflow |=> r_ff.near && r_ff.istat[0];
	endproperty
	a_near_set: assert property (p_near_set) else $error("near flag not set");

	property p_trim;
		@(posedge aclk) disable iff (!aresetn)
			(s_axi_arvalid && s_axi_arready && ar_idx == `WW_IDX_TRIM && r_ff.tsel == `WW_TSEL_REFMAG)
			|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(reference_magnitude_fuse);
	endproperty
	a_trim: assert property (p_trim) else $error("trim readout wrong");

	property p_prd_reset;
		@(posedge aclk) disable iff (!nv_por_n) $past(!aresetn) |-> r_ff.prd == `WW_PRD_RESET;
	endproperty
	a_prd_reset: assert property (p_prd_reset) else $error("sleep period reset value wrong");
endmodule

// *** test/ww_bank_tb.sv ***
// self-checking bench for the wake, watchdog, trim and protect bank
`timescale 1ns/10ps
`include "ww_params.svh"
module ww_bank_tb;
	// ******************************
	// signals
	// ******************************
	localparam logic [7:0] REV = 8'h3c; // arbitrary value
	logic aclk, aresetn, nv_por_n;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [7:0] reference_magnitude_fuse, clock_write_enable_key, boot_size, engine_code_location;
	logic reference_enable, reference_to_pad, rtc_tick, full_power_mode, battery_low_power_mode;
	logic sleep_mode, wake_in, reset_pin_in, autowake_armed, autowake_expire;
	logic watchdog_near_overflow, watchdog_overflow, watchdog_restart, clock_key_strobe;
	logic erase_req, erase_grant, erase_blocked, irq;
	logic [17:0] erase_addr;
	logic [7:0] key;
	int err_count, total_checks, seed, n_restart, n_expire, n_key, cyc, n0, t, c;
	logic [2:0] wprd [4] = '{3'h2, 3'h1, 3'h0, 3'h7};
	logic wres [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	int wtk [4] = '{8, 8, 4, 28};

	ww_bank #(.SILICON_REVISION(REV), .AW(18), .SHORT_TICKS(4), .LONG_TICKS(8)) dut (
		.aclk, .aresetn, .nv_por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reference_magnitude_fuse,
		.reference_enable, .reference_to_pad, .rtc_tick, .full_power_mode,
		.battery_low_power_mode, .sleep_mode, .wake_in, .reset_pin_in, .autowake_armed,
		.autowake_expire, .watchdog_near_overflow, .watchdog_overflow, .watchdog_restart,
		.clock_write_enable_key, .clock_key_strobe, .erase_req, .erase_addr, .boot_size,
		.engine_code_location, .erase_grant, .erase_blocked, .irq);

	// ******************************
	// clock, rtc ticks and pulse counters
	// ******************************
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// rtc tick every third cycle keeps autowake runs short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		rtc_tick <= (cyc % 3 == 0);
		if (watchdog_restart === 1'b1) n_restart++;
		if (autowake_expire === 1'b1) n_expire++;
		if (clock_key_strobe === 1'b1) n_key++;
	end

	initial begin
		repeat (30000) @(posedge aclk);
		err_count++;
		give_verdict();
	end

	// ******************************
	// tasks
	// ******************************
	task automatic give_verdict();
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic settle();
		repeat (2) @(posedge aclk);
		#1;
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] st);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp, input logic [1:0] rexp);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, exp);
		chk({30'h0, s_axi_rresp}, {30'h0, rexp});
	endtask

	task automatic er(input logic [17:0] a, input logic exp);
		@(posedge aclk);
		erase_req <= 1'b1;
		erase_addr <= a;
		@(posedge aclk);
		erase_req <= 1'b0;
		@(posedge aclk);
		chk({31'h0, erase_blocked}, {31'h0, exp});
		chk({31'h0, erase_grant}, {31'h0, !exp});
	endtask

	// ******************************
	// main sequence
	// ******************************
	initial begin
		seed = 39704;
		{err_count, total_checks, n_restart, n_expire, n_key, cyc} = '0;
		{aresetn, nv_por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{rtc_tick, full_power_mode, battery_low_power_mode, sleep_mode, wake_in} = '0;
		{reset_pin_in, watchdog_near_overflow, watchdog_overflow, erase_req, erase_addr} = '0;
		reference_magnitude_fuse = 8'($random(seed));
		boot_size = 8'h04;
		engine_code_location = 8'hc0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		nv_por_n <= 1'b1;
		rdchk(`WW_IDX_WAKE, 32'h1, `WW_RESP_OKAY);
		rdchk(`WW_IDX_REF, 32'h0, `WW_RESP_OKAY);
		chk({31'h0, reference_enable}, 32'h1);
		rdchk(`WW_IDX_TSEL, 32'h0, `WW_RESP_OKAY);
		rdchk(14'h1234, 32'h0, `WW_RESP_SLVERR);
		// trim readout follows selector
		wr(`WW_IDX_TSEL, {4'h0, `WW_TSEL_REFMAG}, 4'h1);
		rdchk(`WW_IDX_TRIM, {24'h0, reference_magnitude_fuse}, `WW_RESP_OKAY);
		wr(`WW_IDX_TSEL, 8'h02, 4'h1);
		rdchk(`WW_IDX_TRIM, 32'h0, `WW_RESP_OKAY);
		wr(`WW_IDX_VER, ~REV, 4'h1);
		chk({30'h0, resp}, {30'h0, `WW_RESP_OKAY});
		rdchk(`WW_IDX_VER, {24'h0, REV}, `WW_RESP_OKAY);
		// reference routing, then disable overriding it
		wr(`WW_IDX_REF, 8'h80, 4'h1);
		settle();
		chk({30'h0, reference_to_pad, reference_enable}, 32'h3);
		wr(`WW_IDX_REF, 8'h88, 4'h1);
		settle();
		chk({30'h0, reference_to_pad, reference_enable}, 32'h0);
		// only a full-byte 0xff restarts the watchdog
		wr(`WW_IDX_WDRST, `WW_RESTART_KEY, 4'h1);
		wr(`WW_IDX_WDRST, 8'hfe, 4'h1);
		wr(`WW_IDX_WDRST, `WW_RESTART_KEY, 4'h0);
		settle();
		chk(n_restart, 32'h1);
		// overflow status survives system reset, cleared by pin, sleep and firmware
		@(posedge aclk) watchdog_overflow <= 1'b1;
		@(posedge aclk) watchdog_overflow <= 1'b0;
		settle();
		rdchk(`WW_IDX_WDOVF, 32'h4, `WW_RESP_OKAY);
		@(posedge aclk) aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(`WW_IDX_WDOVF, 32'h4, `WW_RESP_OKAY);
		@(posedge aclk) reset_pin_in <= 1'b1;
		repeat (4) @(posedge aclk);
		reset_pin_in <= 1'b0;
		rdchk(`WW_IDX_WDOVF, 32'h0, `WW_RESP_OKAY);
		@(posedge aclk) watchdog_overflow <= 1'b1;
		@(posedge aclk) watchdog_overflow <= 1'b0;
		sleep_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		sleep_mode <= 1'b0;
		rdchk(`WW_IDX_WDOVF, 32'h0, `WW_RESP_OKAY);
		@(posedge aclk) watchdog_overflow <= 1'b1;
		@(posedge aclk) watchdog_overflow <= 1'b0;
		wr(`WW_IDX_WDOVF, 8'h00, 4'h1);
		rdchk(`WW_IDX_WDOVF, 32'h0, `WW_RESP_OKAY);
		// near-overflow flag, sticky interrupt status and mask
		wr(`WW_IDX_IMASK, 8'h01, 4'h1);
		@(posedge aclk) watchdog_near_overflow <= 1'b1;
		@(posedge aclk) watchdog_near_overflow <= 1'b0;
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(`WW_IDX_NEAR, 8'h01, 4'h1);
		rdchk(`WW_IDX_NEAR, 32'h1, `WW_RESP_OKAY);
		wr(`WW_IDX_NEAR, 8'h00, 4'h1);
		rdchk(`WW_IDX_NEAR, 32'h0, `WW_RESP_OKAY);
		wr(`WW_IDX_ISTAT, 8'h01, 4'h1);
		settle();
		chk({31'h0, irq}, 32'h0);
		wr(`WW_IDX_IMASK, 8'h00, 4'h1);
		@(posedge aclk) watchdog_near_overflow <= 1'b1;
		@(posedge aclk) watchdog_near_overflow <= 1'b0;
		wake_in <= 1'b1;
		repeat (5) @(posedge aclk);
		wake_in <= 1'b0;
		settle();
		chk({31'h0, irq}, 32'h0);
		rdchk(`WW_IDX_NEAR, 32'h0, `WW_RESP_OKAY);
		wr(`WW_IDX_ISTAT, 8'h0f, 4'h1);
		// clock key lands on the output with one strobe
		key = 8'($random(seed));
		wr(`WW_IDX_KEY, key, 4'h1);
		settle();
		chk({24'h0, clock_write_enable_key}, {24'h0, key});
		chk(n_key, 32'h1);
		// autowake length is period times step, period zero one step, counted in rtc ticks
		for (int i = 0; i < 4; i++) begin
			n0 = n_expire;
			t = 0;
			c = 0;
			wr(`WW_IDX_WAKE, {4'h8, wres[i], wprd[i]}, 4'h1);
			while (n_expire == n0 && c < 400) begin
				@(posedge aclk);
				#1;
				c++;
				if (rtc_tick === 1'b1) t++;
			end
			chk({31'h0, (t >= wtk[i] - 1 && t <= wtk[i] + 1)}, 32'h1);
			rdchk(`WW_IDX_WAKE, {28'h0, wres[i], wprd[i]}, `WW_RESP_OKAY);
		end
		// full and battery modes keep the timer disarmed
		for (int m = 0; m < 2; m++) begin
			n0 = n_expire;
			wr(`WW_IDX_WAKE, 8'h81, 4'h1);
			@(posedge aclk) {battery_low_power_mode, full_power_mode} <= (m == 0) ? 2'h1 : 2'h2;
			repeat (60) @(posedge aclk);
			chk({31'h0, autowake_armed}, 32'h0);
			chk(n_expire, n0);
			{battery_low_power_mode, full_power_mode} <= 2'h0;
		end
		// arm, let more than three rtc ticks pass, then command sleep
		wr(`WW_IDX_WAKE, 8'h87, 4'h1);
		repeat (12) @(posedge aclk);
		sleep_mode <= 1'b1;
		repeat (2) @(posedge aclk);
		chk({31'h0, autowake_armed}, 32'h1);
		sleep_mode <= 1'b0;
		// erase protection boundaries, blocked event raises the interrupt
		wr(`WW_IDX_IMASK, 8'h08, 4'h1);
		wr(`WW_IDX_PROT, 8'h30, 4'h1);
		rdchk(`WW_IDX_PROT, 32'h30, `WW_RESP_OKAY);
		er(18'h0, 1'b1);
		er(18'h00fff, 1'b1);
		er(18'h01000, 1'b0);
		er(18'h2ffff, 1'b0);
		er(18'h30000, 1'b1);
		er(18'h3ffff, 1'b1);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(`WW_IDX_PROT, 8'h20, 4'h1);
		er(18'h30000, 1'b0);
		er(18'h00000, 1'b1);
		wr(`WW_IDX_PROT, 8'h10, 4'h1);
		er(18'h00000, 1'b0);
		er(18'h30000, 1'b1);
		give_verdict();
	end
endmodule
